//--- design/salr_top.sv
// Lookup-table read-back, command status and configuration registers
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/100ps
// How it works
// - Priority applies only when entry and global enabled
// - Port code decodes to single, multiple or no ports
// - Low sixteen bits return the MAC tail
// - Init-done flag sets itself after table init
// - Packets dropped during about twenty microseconds init
// - Pending bit set during command, clears itself
// - Aging time is value plus one units
// - Config bit two permits broadcast table entries
// - Config bit one enables aging, resets set
// - Config bit zero switches aging unit milliseconds
// - Read-back words loaded by get-entry commands
// - Bit twenty-two reports entry priority enable
module salr_top
    import salr_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES,  // Cycles per millisecond
    parameter int S_CYC  = S_CYCLES    // Cycles per second
) (
    input  wire logic        ref_clk,          // Core clock, 200 MHz
    input  wire logic        rst,              // Fabric reset, async high
    input  wire logic        hsel,             // AHB slave select
    input  wire logic [31:0] haddr,            // AHB address
    input  wire logic [1:0]  htrans,           // AHB transfer type
    input  wire logic        hwrite,           // AHB write
    input  wire logic [2:0]  hsize,            // AHB size
    input  wire logic        hready,           // AHB bus ready
    input  wire logic [31:0] hwdata,           // AHB write data
    output logic      [31:0] hrdata,           // AHB read data
    output logic             hreadyout,        // AHB slave ready
    output logic             hresp,            // AHB response
    input  wire logic        cmd_start,        // Table command begins
    input  wire logic        cmd_done,         // Table command ends
    input  wire logic        cmd_get_entry,    // Get first/next issued
    input  wire logic        entry_load,       // Read-back load strobe
    input  wire logic [31:0] entry_lower,      // First 32 MAC bits
    input  wire logic [27:0] entry_upper,      // Upper word fields
    input  wire logic        match_valid,      // Destination match seen
    input  wire logic        match_prio_en,    // Matched entry prio en
    input  wire logic [2:0]  match_prio,       // Matched entry priority
    input  wire logic [2:0]  match_port,       // Matched entry port code
    input  wire logic        dest_priority_global_en, // Global DA prio
    input  wire logic        chk_valid,        // Entry write to check
    input  wire logic [47:0] chk_mac,          // MAC of that entry
    output logic             pkt_prio_valid,   // Priority override valid
    output logic      [2:0]  pkt_prio,         // Priority to use
    output logic      [2:0]  fwd_port_mask,    // Ports of matched entry
    output logic      [2:0]  rd_port_mask,     // Ports of read-back entry
    output logic             entry_permit,     // Entry may be stored
    output logic             drop_rx,          // Drop received packets
    output logic             table_init_complete, // Table init done
    output logic             age_tick          // Aging period elapsed
);
    if (MS_CYC < 1 || S_CYC < MS_CYC) begin : g_chk
        $error("salr_top: unit counts out of range");
    end

    salr_ctl_if ctl ();

    salr_init u_init (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ctl     (ctl.init)
    );

    salr_age #(
        .MS_CYC (MS_CYC),
        .S_CYC  (S_CYC)
    ) u_age (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ctl     (ctl.age)
    );

    // Bus address phase capture
    logic        wr_pend_reg;
    logic        wr_pend_next;
    logic [31:0] wr_addr_reg;
    logic [31:0] wr_addr_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        take;

    // Register state
    logic [31:0] lower_reg;
    logic [31:0] lower_next;
    logic [31:0] upper_reg;
    logic [31:0] upper_next;
    logic        pend_reg;
    logic        pend_next;
    logic [11:0] age_time_reg;
    logic [11:0] age_time_next;
    logic        bcast_reg;
    logic        bcast_next;
    logic        age_en_reg;
    logic        age_en_next;
    logic        test_reg;
    logic        test_next;

    // Packet-side results
    logic        prio_v_reg;
    logic        prio_v_next;
    logic [2:0]  prio_reg;
    logic [2:0]  prio_next;
    logic [2:0]  fwd_reg;
    logic [2:0]  fwd_next;
    logic [2:0]  rdm_reg;
    logic [2:0]  rdm_next;
    logic        permit_reg;
    logic        permit_next;

    logic [31:0] sts_word;
    logic [31:0] cfg_word;

    assign take = hsel && hready && htrans[1];

    assign sts_word = {30'h0, ctl.init_done, pend_reg};
    assign cfg_word = {4'h0, age_time_reg, 13'h0000,
                       bcast_reg, age_en_reg, test_reg};

    // Read data is fixed in the address phase so hrdata is a flop
    always_comb begin
        wr_pend_next = take && hwrite;
        wr_addr_next = take ? haddr : wr_addr_reg;
        rdata_next   = rdata_reg;
        if (take && !hwrite) begin
            unique case (haddr)
                RD_LOWER_ADDR: rdata_next = lower_reg;
                RD_UPPER_ADDR: rdata_next = upper_reg;
                CMD_STS_ADDR:  rdata_next = sts_word;
                CFG_ADDR:      rdata_next = cfg_word;
                default:       rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        lower_next    = lower_reg;
        upper_next    = upper_reg;
        pend_next     = pend_reg;
        age_time_next = age_time_reg;
        bcast_next    = bcast_reg;
        age_en_next   = age_en_reg;
        test_next     = test_reg;
        // Get-entry clears valid before the search result lands
        if (cmd_get_entry) begin
            upper_next[UP_VALID_BIT] = 1'b0;
        end
        if (entry_load) begin
            lower_next = entry_lower;
            upper_next = {4'h0, entry_upper};
        end
        // Start wins over done in the same cycle
        if (cmd_start) begin
            pend_next = 1'b1;
        end else if (cmd_done) begin
            pend_next = 1'b0;
        end
        // Only the configuration word is writable
        if (wr_pend_reg && wr_addr_reg == CFG_ADDR) begin
            age_time_next = hwdata[CFG_AGE_MSB:CFG_AGE_LSB];
            bcast_next    = hwdata[CFG_BCAST_BIT];
            age_en_next   = hwdata[CFG_AGE_EN_BIT];
            test_next     = hwdata[CFG_TEST_BIT];
        end
    end

    always_comb begin
        prio_v_next = match_valid && match_prio_en
                      && dest_priority_global_en;
        prio_next   = match_valid ? match_prio : prio_reg;
        fwd_next    = match_valid ? salr_port_mask(match_port)
                                  : fwd_reg;
        rdm_next    = salr_port_mask(
                          upper_reg[UP_PORT_MSB:UP_PORT_LSB]);
        permit_next = permit_reg;
        if (chk_valid) begin
            permit_next = (chk_mac != 48'hffff_ffff_ffff)
                          || bcast_reg;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_pend_reg  <= 1'b0;
            wr_addr_reg  <= 32'h0000_0000;
            rdata_reg    <= 32'h0000_0000;
            lower_reg    <= 32'h0000_0000;
            upper_reg    <= UP_RESET;
            pend_reg     <= PEND_RESET;
            age_time_reg <= CFG_AGE_RESET;
            bcast_reg    <= CFG_BCAST_RESET;
            age_en_reg   <= CFG_AGE_EN_RESET;
            test_reg     <= CFG_TEST_RESET;
            prio_v_reg   <= 1'b0;
            prio_reg     <= 3'h0;
            fwd_reg      <= 3'h0;
            rdm_reg      <= 3'h0;
            permit_reg   <= 1'b0;
        end else begin
            wr_pend_reg  <= wr_pend_next;
            wr_addr_reg  <= wr_addr_next;
            rdata_reg    <= rdata_next;
            lower_reg    <= lower_next;
            upper_reg    <= upper_next;
            pend_reg     <= pend_next;
            age_time_reg <= age_time_next;
            bcast_reg    <= bcast_next;
            age_en_reg   <= age_en_next;
            test_reg     <= test_next;
            prio_v_reg   <= prio_v_next;
            prio_reg     <= prio_next;
            fwd_reg      <= fwd_next;
            rdm_reg      <= rdm_next;
            permit_reg   <= permit_next;
        end
    end

    assign ctl.age_time = age_time_reg;
    assign ctl.age_en   = age_en_reg;
    assign ctl.age_ms   = test_reg;

    // Zero-wait slave, never an error response
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_reg;

    assign pkt_prio_valid      = prio_v_reg;
    assign pkt_prio            = prio_reg;
    assign fwd_port_mask       = fwd_reg;
    assign rd_port_mask        = rdm_reg;
    assign entry_permit        = permit_reg;
    assign drop_rx             = !ctl.init_done;
    assign table_init_complete = ctl.init_done;
    assign age_tick            = ctl.age_tick;

    property p_prio;
        @(posedge ref_clk) disable iff (rst)
        match_valid && !(match_prio_en && dest_priority_global_en)
        |=> !pkt_prio_valid;
    endproperty
    a_prio: assert property (p_prio)
        else $error("priority applied without both enables");

    property p_port;
        @(posedge ref_clk) disable iff (rst)
        match_valid && match_port == 3'h3 |=> fwd_port_mask == 3'h0;
    endproperty
    a_port: assert property (p_port)
        else $error("reserved port code selected a port");

    property p_load;
        @(posedge ref_clk) disable iff (rst)
        entry_load |=> upper_reg[15:0] == $past(entry_upper[15:0])
                       && upper_reg[22] == $past(entry_upper[22]);
    endproperty
    a_load: assert property (p_load)
        else $error("read-back upper word not loaded");

    property p_pend;
        @(posedge ref_clk) disable iff (rst)
        cmd_start ##1 (!cmd_done [*2]) |-> pend_reg;
    endproperty
    a_pend: assert property (p_pend)
        else $error("pending lost before command done");

    property p_pend_clr;
        @(posedge ref_clk) disable iff (rst)
        cmd_done && !cmd_start |=> !sts_word[STS_PEND_BIT];
    endproperty
    a_pend_clr: assert property (p_pend_clr)
        else $error("pending did not clear");

    property p_cfg_wr;
        @(posedge ref_clk) disable iff (rst)
        take && hwrite && haddr == CFG_ADDR ##1 1'b1
        |=> cfg_word == ($past(hwdata) & 32'h0fff_0007);
    endproperty
    a_cfg_wr: assert property (p_cfg_wr)
        else $error("configuration write not stored");

    property p_bcast;
        @(posedge ref_clk) disable iff (rst)
        chk_valid && chk_mac == 48'hffff_ffff_ffff && !bcast_reg
        |=> !entry_permit;
    endproperty
    a_bcast: assert property (p_bcast)
        else $error("broadcast entry permitted while disallowed");

    property p_ro;
        @(posedge ref_clk) disable iff (rst)
        take && hwrite && haddr != CFG_ADDR && !entry_load
        && !cmd_get_entry ##1 !entry_load && !cmd_get_entry
        |=> upper_reg == $past(upper_reg, 2);
    endproperty
    a_ro: assert property (p_ro)
        else $error("write changed a read-only word");

    property p_sts_rd;
        @(posedge ref_clk) disable iff (rst)
        take && !hwrite && haddr == CMD_STS_ADDR
        |=> hrdata[31:2] == 30'h0 && hrdata[1] == $past(ctl.init_done);
    endproperty
    a_sts_rd: assert property (p_sts_rd)
        else $error("status read wrong");
endmodule

//--- design/salr_pkg.sv
// Constants and helpers for the lookup-table status and configuration block
package salr_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [15:0] RD_LOWER_IDX  = 16'h1805;
    localparam logic [15:0] RD_UPPER_IDX  = 16'h1806;
    localparam logic [15:0] CMD_STS_IDX   = 16'h1808;
    localparam logic [15:0] CFG_IDX       = 16'h1809;
    localparam logic [31:0] RD_LOWER_ADDR = {14'h0000, RD_LOWER_IDX, 2'h0};
    localparam logic [31:0] RD_UPPER_ADDR = {14'h0000, RD_UPPER_IDX, 2'h0};
    localparam logic [31:0] CMD_STS_ADDR  = {14'h0000, CMD_STS_IDX, 2'h0};
    localparam logic [31:0] CFG_ADDR      = {14'h0000, CFG_IDX, 2'h0};

    // Read-back upper word fields
    localparam int UP_EOT_BIT     = 27;
    localparam int UP_VALID_BIT   = 26;
    localparam int UP_PRIO_EN_BIT = 22;
    localparam int UP_PRIO_MSB    = 21;
    localparam int UP_PRIO_LSB    = 19;
    localparam int UP_PORT_MSB    = 18;
    localparam int UP_PORT_LSB    = 16;
    localparam int UP_MAC_MSB     = 15;
    localparam logic [31:0] UP_RESET = 32'h0000_0000;

    // Command status fields
    localparam int STS_INIT_BIT = 1;
    localparam int STS_PEND_BIT = 0;
    localparam logic PEND_RESET = 1'b0;

    // Configuration fields and reset values
    localparam int CFG_AGE_MSB   = 27;
    localparam int CFG_AGE_LSB   = 16;
    localparam int CFG_BCAST_BIT = 2;
    localparam int CFG_AGE_EN_BIT = 1;
    localparam int CFG_TEST_BIT  = 0;
    localparam logic [11:0] CFG_AGE_RESET    = 12'h129;
    localparam logic        CFG_BCAST_RESET  = 1'b0;
    localparam logic        CFG_AGE_EN_RESET = 1'b1;
    localparam logic        CFG_TEST_RESET   = 1'b0;

    // Timing at a 5 ns clock
    localparam int CLK_PERIOD_NS = 5;
    localparam int INIT_TIME_NS  = 20000;
    localparam int INIT_CYCLES   = INIT_TIME_NS / CLK_PERIOD_NS;
    localparam int MS_TIME_NS    = 1000000;
    localparam int S_TIME_NS     = 1000000000;
    localparam int MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;
    localparam int S_CYCLES      = S_TIME_NS / CLK_PERIOD_NS;

    // Port code to a mask of ports 2..0; the reserved code gives no port
    function automatic logic [2:0] salr_port_mask(input logic [2:0] code);
        logic [2:0] m;
        m = 3'h0;
        unique case (code)
            3'h0: m = 3'h1;
            3'h1: m = 3'h2;
            3'h2: m = 3'h4;
            3'h3: m = 3'h0;
            3'h4: m = 3'h3;
            3'h5: m = 3'h5;
            3'h6: m = 3'h6;
            3'h7: m = 3'h7;
        endcase
        return m;
    endfunction
endpackage

//--- design/salr_ctl_if.sv
// Control carrier between the register core, aging timer and table init
`timescale 1ns/100ps
interface salr_ctl_if;
    logic [11:0] age_time;
    logic        age_en;
    logic        age_ms;
    logic        age_tick;
    logic        init_done;
    modport core (output age_time, output age_en, output age_ms,
                  input age_tick, input init_done);
    modport age  (input age_time, input age_en, input age_ms,
                  output age_tick);
    modport init (output init_done);
endinterface

//--- design/salr_init.sv
// Table initialisation sequencer run after each fabric reset
`timescale 1ns/100ps
module salr_init
    import salr_pkg::*;
(
    input wire logic ref_clk,  // Core clock
    input wire logic rst,      // Fabric reset, async high
    salr_ctl_if.init ctl       // Init done flag out
);
    localparam int CW = $clog2(INIT_CYCLES + 1);
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          done_reg;
    logic          done_next;

    always_comb begin
        cnt_next  = cnt_reg;
        done_next = done_reg;
        if (!done_reg) begin
            if (cnt_reg == CW'(INIT_CYCLES - 1)) begin
                done_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_reg  <= '0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            done_reg <= done_next;
        end
    end

    assign ctl.init_done = done_reg;

    property p_init_len;
        @(posedge ref_clk) disable iff (rst)
        $rose(done_reg) |-> $past(cnt_reg) == CW'(INIT_CYCLES - 1);
    endproperty
    a_init_len: assert property (p_init_len)
        else $error("init done not after 20 us");

    property p_init_stay;
        @(posedge ref_clk) disable iff (rst)
        done_reg |=> done_reg;
    endproperty
    a_init_stay: assert property (p_init_stay)
        else $error("init done dropped without reset");
endmodule

//--- design/salr_age.sv
// Aging period timer in seconds or test milliseconds
`timescale 1ns/100ps
module salr_age
    import salr_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES,  // Cycles per millisecond
    parameter int S_CYC  = S_CYCLES    // Cycles per second
) (
    input wire logic ref_clk,  // Core clock
    input wire logic rst,      // Fabric reset, async high
    salr_ctl_if.age  ctl       // Aging settings and tick
);
    if (MS_CYC < 1 || S_CYC < MS_CYC) begin : g_chk
        $error("salr_age: unit counts out of range");
    end

    logic [31:0] pre_reg;
    logic [31:0] pre_next;
    logic [11:0] unit_reg;
    logic [11:0] unit_next;
    logic        tick_reg;
    logic        tick_next;
    logic        unit_pulse;
    logic [31:0] unit_len;

    // Test mode swaps the unit, not the programmed count
    assign unit_len   = ctl.age_ms ? 32'(MS_CYC - 1) : 32'(S_CYC - 1);
    assign unit_pulse = ctl.age_en && pre_reg >= unit_len;

    always_comb begin
        pre_next  = pre_reg;
        unit_next = unit_reg;
        tick_next = 1'b0;
        if (!ctl.age_en) begin
            pre_next  = '0;
            unit_next = '0;
        end else if (unit_pulse) begin
            pre_next = '0;
            if (unit_reg >= ctl.age_time) begin
                unit_next = '0;
                tick_next = 1'b1;
            end else begin
                unit_next = unit_reg + 1'b1;
            end
        end else begin
            pre_next = pre_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pre_reg  <= '0;
            unit_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            pre_reg  <= pre_next;
            unit_reg <= unit_next;
            tick_reg <= tick_next;
        end
    end

    assign ctl.age_tick = tick_reg;

    property p_age_off;
        @(posedge ref_clk) disable iff (rst)
        !ctl.age_en ##1 !ctl.age_en |-> !tick_reg;
    endproperty
    a_age_off: assert property (p_age_off)
        else $error("aging tick while aging disabled");

    property p_age_unit;
        @(posedge ref_clk) disable iff (rst)
        // A unit switch mid-count may cut that one period short
        unit_pulse && ctl.age_ms && $past(ctl.age_ms)
        |-> pre_reg == 32'(MS_CYC - 1);
    endproperty
    a_age_unit: assert property (p_age_unit)
        else $error("test unit is not one millisecond");
endmodule

//--- tb/salr_top_tb.sv
// Self-checking bench for lookup-table status and configuration registers
`timescale 1ns/100ps
`define CHK(got, exp) check_val(32'(got), 32'(exp))
module salr_top_tb;
    import salr_pkg::*;
    localparam int LIMIT = 20000;
    logic        ref_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, entry_lower, rdv;
    logic [1:0]  htrans;
    logic [2:0]  hsize, match_prio, match_port, pkt_prio;
    logic [2:0]  fwd_port_mask, rd_port_mask;
    logic        cmd_start, cmd_done, cmd_get_entry, entry_load;
    logic [27:0] entry_upper;
    logic        match_valid, match_prio_en, dest_priority_global_en;
    logic        chk_valid, pkt_prio_valid, entry_permit, drop_rx;
    logic        table_init_complete, age_tick;
    logic [47:0] chk_mac;
    logic [2:0]  masks [0:7];
    int          n_fail, num_checks, cyc, t0, n;

    // Small unit counts keep the aging checks short
    salr_top #(.MS_CYC(4), .S_CYC(20)) salr_top_i (
        .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .cmd_start(cmd_start), .cmd_done(cmd_done),
        .cmd_get_entry(cmd_get_entry), .entry_load(entry_load),
        .entry_lower(entry_lower), .entry_upper(entry_upper),
        .match_valid(match_valid), .match_prio_en(match_prio_en),
        .match_prio(match_prio), .match_port(match_port),
        .dest_priority_global_en(dest_priority_global_en),
        .chk_valid(chk_valid), .chk_mac(chk_mac),
        .pkt_prio_valid(pkt_prio_valid), .pkt_prio(pkt_prio),
        .fwd_port_mask(fwd_port_mask), .rd_port_mask(rd_port_mask),
        .entry_permit(entry_permit), .drop_rx(drop_rx),
        .table_init_complete(table_init_complete), .age_tick(age_tick));

    // Single slave: its ready is the bus ready
    assign hready = hreadyout;

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_fail++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask

    // Address phase held until ready, then data phase until ready
    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge ref_clk);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wr; hsize <= 3'h2;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        ahb(1'b1, a, d, rdv);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0000_0000, rdv);
        `CHK(rdv, e);
        `CHK(hresp, 1'b0);
    endtask

    task automatic pend(input logic s, input logic d, input logic [31:0] e);
        @(posedge ref_clk); cmd_start <= s; cmd_done <= d;
        @(posedge ref_clk); cmd_start <= 1'b0; cmd_done <= 1'b0;
        rd_chk(CMD_STS_ADDR, e);
    endtask

    task automatic load(input logic [31:0] l, input logic [27:0] u);
        @(posedge ref_clk); entry_load <= 1'b1; entry_lower <= l;
        entry_upper <= u;
        @(posedge ref_clk); entry_load <= 1'b0;
    endtask

    task automatic bcast(input logic [47:0] mac, input logic e);
        @(posedge ref_clk); chk_valid <= 1'b1; chk_mac <= mac;
        @(posedge ref_clk); chk_valid <= 1'b0;
        #1;
        `CHK(entry_permit, e);
    endtask

    // Second tick after the first gives one full period
    task automatic age_period(input int e);
        int k;
        k = 0;
        while (age_tick !== 1'b1 && k < 400) begin step(); k++; end
        k = 0;
        do begin step(); k++; end while (age_tick !== 1'b1 && k < 400);
        `CHK(k, e);
    endtask

    initial begin
        masks = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7};
        rst = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = '0; cmd_start = 1'b0; cmd_done = 1'b0;
        cmd_get_entry = 1'b0; entry_load = 1'b0; entry_lower = '0;
        entry_upper = '0; match_valid = 1'b0; match_prio_en = 1'b0;
        match_prio = 3'h0; match_port = 3'h0; dest_priority_global_en = 1'b0;
        chk_valid = 1'b0; chk_mac = '0; n_fail = 0; num_checks = 0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        t0 = cyc;
        `CHK(drop_rx, 1'b1);
        rd_chk(CFG_ADDR, 32'h0129_0002);
        rd_chk(CMD_STS_ADDR, 32'h0000_0000);
        rd_chk(RD_UPPER_ADDR, 32'h0000_0000);
        // Software polls init-done before any table register write
        while (table_init_complete !== 1'b1 && cyc - t0 < 4100)
            step();
        `CHK(cyc - t0, INIT_CYCLES);
        `CHK(drop_rx, 1'b0);
        rd_chk(CMD_STS_ADDR, 32'h0000_0002);
        $display("test init done");
        wr_reg(CFG_ADDR, 32'hffff_ffff);
        rd_chk(CFG_ADDR, 32'h0fff_0007);
        wr_reg(CMD_STS_ADDR, 32'hffff_ffff);
        wr_reg(RD_UPPER_ADDR, 32'hffff_ffff);
        rd_chk(CMD_STS_ADDR, 32'h0000_0002);
        rd_chk(RD_UPPER_ADDR, 32'h0000_0000);
        rd_chk(32'h0000_6028, 32'h0000_0000);
        $display("test register access done");
        pend(1'b1, 1'b1, 32'h0000_0003);
        pend(1'b0, 1'b1, 32'h0000_0002);
        pend(1'b1, 1'b0, 32'h0000_0003);
        pend(1'b0, 1'b1, 32'h0000_0002);
        $display("test pending done");
        load(32'h1234_5678, 28'h46a_beef);
        rd_chk(RD_LOWER_ADDR, 32'h1234_5678);
        rd_chk(RD_UPPER_ADDR, 32'h046a_beef);
        @(posedge ref_clk); cmd_get_entry <= 1'b1;
        @(posedge ref_clk); cmd_get_entry <= 1'b0;
        rd_chk(RD_UPPER_ADDR, 32'h006a_beef);
        load(32'h0000_0000, 28'hfff_ffff);
        rd_chk(RD_UPPER_ADDR, 32'h0fff_ffff);
        for (int i = 0; i < 8; i++) begin
            load(32'h0000_0000, {9'h000, 3'(i), 16'h0000});
            step();
            `CHK(rd_port_mask, masks[i]);
        end
        $display("test read-back done");
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk); match_valid <= 1'b1; match_port <= 3'(i);
            match_prio_en <= i[0]; dest_priority_global_en <= i[1];
            match_prio <= 3'h7 - 3'(i);
            @(posedge ref_clk); match_valid <= 1'b0;
            #1;
            `CHK(pkt_prio_valid, i[0] & i[1]);
            `CHK(pkt_prio, 3'h7 - 3'(i));
            `CHK(fwd_port_mask, masks[i]);
        end
        $display("test priority done");
        wr_reg(CFG_ADDR, 32'h0000_0002);
        bcast(48'hffff_ffff_ffff, 1'b0);
        bcast(48'h0123_4567_89ab, 1'b1);
        wr_reg(CFG_ADDR, 32'h0000_0004);
        bcast(48'hffff_ffff_ffff, 1'b1);
        $display("test broadcast done");
        wr_reg(CFG_ADDR, 32'h0001_0003);
        age_period(8);
        wr_reg(CFG_ADDR, 32'h0000_0002);
        age_period(20);
        wr_reg(CFG_ADDR, 32'h0000_0001);
        n = 0;
        repeat (60) begin step(); if (age_tick !== 1'b0) n++; end
        `CHK(n, 0);
        $display("test aging done");
        @(posedge ref_clk); rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        step();
        `CHK(table_init_complete, 1'b0);
        `CHK(drop_rx, 1'b1);
        rd_chk(CFG_ADDR, 32'h0129_0002);
        $display("test second reset done");
        summarize();
    end
endmodule
